// >>> verilog/firtf_pkg.sv
// Package with widths and constants of the three-tap FIR filter
package firtf_pkg;
  localparam int SAMPLE_W = 8;
  localparam int OUT_W = 20;
  localparam int TAPS = 3;
  localparam int NARROW_PROD_W = 14;
  localparam int WIDE_PROD_W = 16;
  localparam int SUM_W = 18;
  localparam int TRUNC_BITS = 4;
  localparam int SUM_GROWTH = 2;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_RESET = 8'sh00;
  localparam logic signed [SAMPLE_W-1:0] COEF_OUTER = 8'sh01;
  localparam logic signed [SAMPLE_W-1:0] COEF_CENTER = 8'shfb;

  typedef logic signed [SAMPLE_W-1:0] firtf_sample_t;

  typedef struct packed {
    logic valid;
    firtf_sample_t data;
  } firtf_in_t;

  typedef struct packed {
    logic valid;
    logic signed [OUT_W-1:0] data;
  } firtf_out_t;
endpackage : firtf_pkg

// >>> verilog/firtf_filter.sv
// Three-tap fixed-point FIR filter with coefficients 1, -5, 1
// Notes on behaviour
// - Signed 8-bit input, one sample per clock
// - Signed 20-bit output carries filter result
// - Three chained 8-bit delay registers shift
// - Output sums taps times coefficients 1,-5,1
// - Three multipliers feed one three-input adder
// - Product width is sum of operand widths
// - 14-bit products sign-extended to 16 bits
// - Three-operand sum grows two bits: 18
// - Value carried as L+R bits, MSB sign
// - Unsigned width w carried as signed w+1
// - Binary point never changes stored bits
// - Optional 4-bit truncation of each product
// - Delay stages inherit input sample width
// - Delay registers update on rising clock edge
// - Active-low reset initialises registers
module firtf_filter
  import firtf_pkg::*;
#(
  parameter bit TRUNCATE = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Sample stream
  input firtf_in_t sampleIn,
  output firtf_out_t sampleOut
);

  firtf_sample_t tap_reg [TAPS];
  logic validDelay_reg;
  logic signed [WIDE_PROD_W-1:0] prod [TAPS];
  logic signed [SUM_W-1:0] sum_next;

  function automatic logic signed [SAMPLE_W:0] widenUnsigned(input logic [SAMPLE_W-1:0] u);
    widenUnsigned = $signed({1'b0, u});
  endfunction : widenUnsigned

  function automatic logic signed [WIDE_PROD_W-1:0] mulTap(input firtf_sample_t x,
                                                          input firtf_sample_t c);
    logic signed [WIDE_PROD_W-1:0] p;
    p = x * c;
    if (TRUNCATE) begin
      p = p >>> TRUNC_BITS;
    end
    mulTap = p;
  endfunction : mulTap

  // Sign extension of a narrow product
  function automatic logic signed [WIDE_PROD_W-1:0] extendNarrow(
    input logic signed [NARROW_PROD_W-1:0] n);
    extendNarrow = WIDE_PROD_W'(n);
  endfunction : extendNarrow

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < TAPS; i++) begin
        tap_reg[i] <= SAMPLE_RESET;
      end
    end else if (clkEn) begin
      tap_reg[0] <= sampleIn.data;
      for (int i = 1; i < TAPS; i++) begin
        tap_reg[i] <= tap_reg[i-1];
      end
    end
  end

  // Valid only marks samples; data still moves on every enabled cycle
  // Valid pipe cleared by reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      validDelay_reg <= 1'b0;
    end else if (clkEn) begin
      validDelay_reg <= sampleIn.valid;
    end
  end

  generate
    for (genvar g = 0; g < TAPS; g++) begin : gTap
      localparam firtf_sample_t COEF = (g == 1) ? COEF_CENTER : COEF_OUTER;
      logic signed [WIDE_PROD_W-1:0] full;
      assign full = mulTap(tap_reg[g], COEF);
      if (g == 1) begin : gWide
        assign prod[g] = full;
      end else begin : gNarrow
        // Outer tap carried at 14 bits
        // Unit weight never needs the top bits, so the multiplier can shrink
        logic signed [NARROW_PROD_W-1:0] narrow;
        assign narrow = NARROW_PROD_W'(full);
        assign prod[g] = extendNarrow(narrow);
      end
    end
  endgenerate

  // Full 18-bit sum, so no product combination can wrap
  // Outer products are 14-bit, sign-extended
  // Adder grows two bits to 18
  always_comb begin
    sum_next = SUM_W'(prod[0]) + SUM_W'(prod[1]) + SUM_W'(prod[2]);
  end

  // Sign carried in MSB by extension
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sampleOut <= '0;
    end else if (clkEn) begin
      sampleOut.data <= OUT_W'(sum_next);
      sampleOut.valid <= validDelay_reg;
    end
  end

  // Operand of the unsigned path checked for a zero top bit
  logic signed [SAMPLE_W:0] widenProbe;
  assign widenProbe = widenUnsigned(sampleIn.data);

  a_unsigned_widen_zero:
    assert property (@(posedge clk) disable iff (!reset_n) widenProbe[SAMPLE_W] == 1'b0)
      else $error("Widened unsigned value has set top bit");

  a_delay_shift_chain:
    assert property (@(posedge clk) disable iff (!reset_n)
      clkEn |=> tap_reg[2] == $past(tap_reg[1]) && tap_reg[1] == $past(tap_reg[0]))
      else $error("Delay line did not shift");

  a_first_tap_load:
    assert property (@(posedge clk) disable iff (!reset_n)
      clkEn |=> tap_reg[0] == $past(sampleIn.data))
      else $error("First tap missed the sample");

  a_reset_clears_taps:
    assert property (@(posedge clk) !reset_n |=> tap_reg[0] == 0 && tap_reg[1] == 0 && tap_reg[2] == 0)
      else $error("Taps not cleared by reset");

  a_output_equation:
    assert property (@(posedge clk) disable iff (!reset_n)
      (!TRUNCATE && clkEn) |=> sampleOut.data ==
        OUT_W'($past(tap_reg[0]) - 5 * $past(tap_reg[1]) + $past(tap_reg[2])))
      else $error("Output does not match weighted sum");

  a_hold_when_idle:
    assert property (@(posedge clk) disable iff (!reset_n)
      !clkEn |=> $stable(sampleOut.data) && $stable(tap_reg[0]))
      else $error("State changed while enable low");

  a_output_sign_ext:
    assert property (@(posedge clk) disable iff (!reset_n)
      sampleOut.data[OUT_W-1:SUM_W-1] == {(OUT_W-SUM_W+1){sampleOut.data[OUT_W-1]}})
      else $error("Output not sign extended");

  a_outer_prod_range:
    assert property (@(posedge clk) disable iff (!reset_n)
      !TRUNCATE |-> prod[0][WIDE_PROD_W-1:NARROW_PROD_W-1] ==
        {(WIDE_PROD_W-NARROW_PROD_W+1){prod[0][WIDE_PROD_W-1]}})
      else $error("Outer product exceeds 14 bits");

  a_valid_latency:
    assert property (@(posedge clk) disable iff (!reset_n)
      clkEn ##1 clkEn |=> sampleOut.valid == $past(sampleIn.valid, 2))
      else $error("Valid latency wrong");

  a_valid_pipe_load:
    assert property (@(posedge clk) disable iff (!reset_n)
      clkEn |=> validDelay_reg == $past(sampleIn.valid))
      else $error("Valid pipe missed the marker");

  a_reset_clears_out:
    assert property (@(posedge clk) !reset_n |=> sampleOut.data == '0 && !sampleOut.valid)
      else $error("Output not cleared by reset");

  a_hold_other_state:
    assert property (@(posedge clk) disable iff (!reset_n)
      !clkEn |=> $stable(sampleOut.valid) && $stable(tap_reg[1]) && $stable(tap_reg[2]))
      else $error("Held state changed while enable low");

  a_outer_prod_value:
    assert property (@(posedge clk) disable iff (!reset_n)
      !TRUNCATE |-> prod[0] == WIDE_PROD_W'(tap_reg[0])
        && prod[2] == WIDE_PROD_W'(tap_reg[2]))
      else $error("Outer product value wrong");

  a_center_prod_value:
    assert property (@(posedge clk) disable iff (!reset_n)
      !TRUNCATE |-> int'(prod[1]) == -5 * int'(tap_reg[1]))
      else $error("Center product value wrong");

  a_trunc_prod_value:
    assert property (@(posedge clk) disable iff (!reset_n)
      TRUNCATE |-> int'(prod[1]) == ((-5 * int'(tap_reg[1])) >>> TRUNC_BITS)
        && int'(prod[0]) == (int'(tap_reg[0]) >>> TRUNC_BITS))
      else $error("Truncated product value wrong");

  a_sum_full_range:
    assert property (@(posedge clk) disable iff (!reset_n)
      int'(sum_next) == int'(prod[0]) + int'(prod[1]) + int'(prod[2]))
      else $error("Adder result lost resolution");

  a_outer_prod_far:
    assert property (@(posedge clk) disable iff (!reset_n)
      prod[2][WIDE_PROD_W-1:NARROW_PROD_W-1] ==
        {(WIDE_PROD_W-NARROW_PROD_W+1){prod[2][WIDE_PROD_W-1]}})
      else $error("Far outer product exceeds 14 bits");

  a_trunc_output:
    assert property (@(posedge clk) disable iff (!reset_n)
      (TRUNCATE && clkEn) |=> int'(sampleOut.data) ==
        (int'($past(tap_reg[0])) >>> TRUNC_BITS)
        + ((-5 * int'($past(tap_reg[1]))) >>> TRUNC_BITS)
        + (int'($past(tap_reg[2])) >>> TRUNC_BITS))
      else $error("Truncated output does not match");

endmodule : firtf_filter

// >>> verification/firtf_source.sv
// Sample source model feeding the filter
module firtf_source
  import firtf_pkg::*;
(
  // Clock and corner control
  input wire logic clk,
  input wire logic corner,
  input firtf_sample_t cornerVal,
  // Random word handed over by the seeded bench
  input wire logic [31:0] randWord,
  // Sample stream
  output firtf_in_t smp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    smp = '0;
    forever begin
      @(negedge clk);
      smp.valid <= randWord[SAMPLE_W];
      smp.data <= corner ? cornerVal : firtf_sample_t'(randWord[SAMPLE_W-1:0]);
    end
  end
endmodule : firtf_source

// >>> verification/test_fir_three_tap_fixed_point.sv
// Self-checking bench for the three-tap filter
module test_fir_three_tap_fixed_point;
  timeunit 1ns;
  timeprecision 1ps;
  import firtf_pkg::*;
  logic clk, reset_n, clkEn, corner;
  logic [31:0] randWord;
  firtf_sample_t cornerVal, t0, t1, t2;
  firtf_in_t sampleIn;
  firtf_out_t expOut, expCut;
  firtf_out_t sampleOut [2];
  logic v0;
  int miscompares, tests_run;

  firtf_source firtf_source_inst (.clk(clk), .corner(corner), .cornerVal(cornerVal),
    .randWord(randWord), .smp(sampleIn));
  // Mode 0 keeps full products, mode 1 drops four bits of each
  for (genvar m = 0; m < 2; m++) begin : gMode
    firtf_filter #(.TRUNCATE(m == 1)) firtf_filter_inst (.clk(clk), .reset_n(reset_n),
      .clkEn(clkEn), .sampleIn(sampleIn), .sampleOut(sampleOut[m]));
  end

  initial clk = 1'b0;
  always #20 clk = ~clk;

  function automatic logic signed [OUT_W-1:0] fir(firtf_sample_t a, b, c);
    return OUT_W'(int'(a) - 5 * int'(b) + int'(c));
  endfunction : fir

  // Each product loses its low bits before the sum
  function automatic logic signed [OUT_W-1:0] firCut(firtf_sample_t a, b, c);
    return OUT_W'((int'(a) >>> TRUNC_BITS) + ((-5 * int'(b)) >>> TRUNC_BITS)
      + (int'(c) >>> TRUNC_BITS));
  endfunction : firCut

  // Reference pipeline; clkEn low freezes it like the design
  always @(posedge clk) begin
    if (!reset_n) begin
      {t0, t1, t2, v0} <= '0;
      expOut <= '0;
      expCut <= '0;
    end else if (clkEn) begin
      {t2, t1, t0} <= {t1, t0, sampleIn.data};
      {expOut.valid, v0} <= {v0, sampleIn.valid};
      expCut.valid <= v0;
      expOut.data <= fir(t0, t1, t2);
      expCut.data <= firCut(t0, t1, t2);
    end
  end

  task automatic check(input firtf_out_t seen, input firtf_out_t exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: output %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    miscompares = 0;
    tests_run = 0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    corner = 1'b1;
    cornerVal = 8'sh80;
    void'($urandom(32'h6d2f9923));
    randWord = $urandom;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    // Extremes first, then random samples, stalls and a reset mid-stream
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      check(sampleOut[0], expOut);
      check(sampleOut[1], expCut);
      randWord <= $urandom;
      cornerVal <= (i % 3 == 0) ? 8'sh7f : 8'sh80;
      corner <= (i < 30);
      clkEn = (i < 100) || ($urandom % 4 != 0);
      reset_n = !(i inside {[300:302]});
    end
    $display("Stream test done");
    finish_test();
  end
endmodule : test_fir_three_tap_fixed_point
